/* File: pkg/gci_frame_pkg.sv */
// Constants, field layouts and carrier types for the GCI frame embedder.
// Assumes a 200 MHz system clock and a classic Wishbone master.
package gci_frame_pkg;
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned C4_HALF_NS  = 30;
  localparam int unsigned C4_HALF_CYC = (C4_HALF_NS * CLK_MHZ) / 1000;
  localparam logic [3:0]  C4_DIV_LAST = 4'(C4_HALF_CYC - 1);

  localparam logic [7:0] ADR_CFG_MAIN  = 8'h00;
  localparam logic [7:0] ADR_CFG_SLOT  = 8'h04;
  localparam logic [7:0] ADR_PCM_MODE  = 8'h08;
  localparam logic [7:0] ADR_SLOT_SEL  = 8'h0c;
  localparam logic [7:0] ADR_SLOT_CFG  = 8'h10;
  localparam logic [7:0] ADR_MON_TX    = 8'h14;
  localparam logic [7:0] ADR_CI_TX     = 8'h18;
  localparam logic [7:0] ADR_MON_RX    = 8'h1c;
  localparam logic [7:0] ADR_CI_RX     = 8'h20;
  localparam logic [7:0] ADR_STATUS    = 8'h24;

  localparam logic [1:0] ROUTE_A_OUT   = 2'h2;
  localparam logic [1:0] ROUTE_B_OUT   = 2'h3;
  localparam logic [1:0] POS_MON       = 2'h2;
  localparam logic [1:0] POS_CI        = 2'h3;
  localparam logic [1:0] RATE_64       = 2'h1;
  localparam logic [1:0] RATE_128      = 2'h2;
  localparam logic [10:0] LAST_32      = 11'h1ff;
  localparam logic [10:0] LAST_64      = 11'h3ff;
  localparam logic [10:0] LAST_128     = 11'h7ff;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [2:0] BIT_PREFETCH  = 3'h4;
  localparam logic [7:0] MON_IDLE      = 8'hff;
  localparam logic [1:0] D_IDLE        = 2'h3;

  typedef struct packed {
    logic       en;
    logic       swap_tx_hs;
    logic       swap_rx_hs;
    logic       swap_lines;
    logic [4:0] group;
  } gci_cfg_type;

  typedef struct packed {
    logic [1:0] route;
    logic       ch_dir;
    logic [3:0] ch_num;
  } slot_entry_type;

  localparam gci_cfg_type    CFG_RESET  = '0;
  localparam slot_entry_type SLOT_RESET = '0;
endpackage

/* File: hdl/gci_frame_embed.sv */
// GCI frame embedder: PCM timing, slot routing and automatic GCI slots.
// Assumes a classic Wishbone master on the system clock and pins that
// are resolved outside from the output enables.
`timescale 1ns/10ps
module gci_frame_embed (
  input  wire logic        CLK_SYS_I,
  input  wire logic        NRST_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        DOUBLE_RATE_BIT_CLOCK_I,
  output logic             DOUBLE_RATE_BIT_CLOCK_O,
  output logic             DOUBLE_RATE_BIT_CLOCK_OE_N_O,
  input  wire logic        FRAME_SYNC_8KHZ_I,
  output logic             FRAME_SYNC_8KHZ_O,
  output logic             FRAME_SYNC_8KHZ_OE_N_O,
  input  wire logic        SERIAL_DATA_LINE_A_I,
  output logic             SERIAL_DATA_LINE_A_O,
  output logic             SERIAL_DATA_LINE_A_OE_N_O,
  input  wire logic        SERIAL_DATA_LINE_B_I,
  output logic             SERIAL_DATA_LINE_B_O,
  output logic             SERIAL_DATA_LINE_B_OE_N_O,
  output logic      [3:0]  CH_TX_NUM_O,
  input  wire logic [7:0]  CH_TX_BYTE_I,
  output logic      [3:0]  CH_RX_NUM_O,
  output logic      [7:0]  CH_RX_BYTE_O,
  output logic             CH_RX_STB_O
);
  gci_frame_pkg::gci_cfg_type    cfg_r;
  gci_frame_pkg::gci_cfg_type    act_r;
  gci_frame_pkg::slot_entry_type slot_tab [0:255];
  gci_frame_pkg::slot_entry_type pend_ent_r;
  gci_frame_pkg::slot_entry_type tx_ent;
  gci_frame_pkg::slot_entry_type rx_ent;
  logic [7:0]  pend_idx_r;
  logic        pend_r;
  logic        pcm_master_r;
  logic [1:0]  rate_r;
  logic [6:0]  sel_num_r;
  logic        sel_dir_r;
  logic [7:0]  mon_tx_r;
  logic [3:0]  ci_tx_r;
  logic        mr_tx_r;
  logic        mx_tx_r;
  logic [7:0]  mon_rx_r;
  logic [3:0]  ci_rx_r;
  logic        mr_rx_r;
  logic        mx_rx_r;
  logic        seen_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_val;
  logic [3:0]  meta_r;
  logic [3:0]  sync_r;
  logic        c4_d_r;
  logic        fs_fall_r;
  logic [3:0]  div_r;
  logic        c4_r;
  logic        c4_oe_n_r;
  logic        fs_r;
  logic        fs_oe_n_r;
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic [10:0] last_cnt;
  logic [7:0]  tx_byte_r;
  logic        a_out_r;
  logic        a_oe_n_r;
  logic        b_out_r;
  logic        b_oe_n_r;
  logic [6:0]  rx_sh_r;
  logic        smp_a_r;
  logic        smp_b_r;
  logic        rx_auto_r;
  logic [1:0]  rx_pos_r;
  logic        rx_ch_en_r;
  logic [3:0]  rx_ch_num_r;
  logic [3:0]  ch_tx_num_r;
  logic [3:0]  ch_rx_num_r;
  logic [7:0]  ch_rx_byte_r;
  logic        ch_rx_stb_r;
  logic        edge_now;
  logic        fs_now;
  logic        frame_go;
  logic        wb_req;
  logic        wb_stall;
  logic        wr_ev;
  logic [6:0]  slot_nx;
  logic [6:0]  slot_nn;
  logic [2:0]  bit_nx;
  logic        half_nx;
  logic [1:0]  pos;
  logic        in_grp;
  logic        auto_any;
  logic        ld_ev;
  logic        smp_ev;
  logic        ld_a;
  logic        ld_b;
  logic        sm_a;
  logic        sm_b;
  logic [7:0]  ld_byte;
  logic [7:0]  rx_byte;

  function automatic logic [10:0] frame_last(input logic [1:0] rate);
    if (rate == gci_frame_pkg::RATE_128) begin
      return gci_frame_pkg::LAST_128;
    end else if (rate == gci_frame_pkg::RATE_64) begin
      return gci_frame_pkg::LAST_64;
    end
    return gci_frame_pkg::LAST_32;
  endfunction

  // Handshake pair as {bit1, bit0}; swap exchanges the two positions
  function automatic logic [1:0] hs_order(input logic swap, input logic mr, input logic mx);
    return swap ? {mx, mr} : {mr, mx};
  endfunction

  // Wishbone slave
  assign wb_req   = WB_CYC_I && WB_STB_I;
  assign wb_stall = WB_WE_I && (WB_ADR_I == gci_frame_pkg::ADR_SLOT_CFG) && pend_r;
  assign wr_ev    = wb_req && WB_WE_I && ack_r && WB_SEL_I[0];

  always_comb begin
    rd_val = '0;
    unique case (WB_ADR_I)
      gci_frame_pkg::ADR_CFG_MAIN: rd_val[3:0] = {cfg_r.swap_lines, cfg_r.swap_rx_hs,
                                                  cfg_r.swap_tx_hs, cfg_r.en};
      gci_frame_pkg::ADR_CFG_SLOT: rd_val[4:0] = cfg_r.group;
      gci_frame_pkg::ADR_PCM_MODE: rd_val[2:0] = {rate_r, pcm_master_r};
      gci_frame_pkg::ADR_SLOT_SEL: rd_val[7:0] = {sel_num_r, sel_dir_r};
      gci_frame_pkg::ADR_SLOT_CFG: rd_val[6:0] = slot_tab[{sel_num_r, sel_dir_r}];
      gci_frame_pkg::ADR_MON_TX:   rd_val[7:0] = mon_tx_r;
      gci_frame_pkg::ADR_CI_TX:    rd_val[5:0] = {mx_tx_r, mr_tx_r, ci_tx_r};
      gci_frame_pkg::ADR_MON_RX:   rd_val[7:0] = mon_rx_r;
      gci_frame_pkg::ADR_CI_RX:    rd_val[5:0] = {mx_rx_r, mr_rx_r, ci_rx_r};
      gci_frame_pkg::ADR_STATUS:   rd_val[2:0] = {seen_r, pend_r, act_r.en};
      default:                     rd_val = '0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      // Table writes stall while one is still waiting for the frame edge
      ack_r <= wb_req && !ack_r && !wb_stall;
      if (wb_req && !ack_r && !wb_stall) begin
        dat_r <= rd_val;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      cfg_r        <= gci_frame_pkg::CFG_RESET;
      pcm_master_r <= 1'b0;
      rate_r       <= '0;
      sel_num_r    <= '0;
      sel_dir_r    <= 1'b0;
      mon_tx_r     <= gci_frame_pkg::MON_IDLE;
      ci_tx_r      <= '0;
      mr_tx_r      <= 1'b1;
      mx_tx_r      <= 1'b1;
    end else if (wr_ev) begin
      unique case (WB_ADR_I)
        gci_frame_pkg::ADR_CFG_MAIN: begin
          cfg_r.en         <= WB_DAT_I[0];
          cfg_r.swap_tx_hs <= WB_DAT_I[1];
          cfg_r.swap_rx_hs <= WB_DAT_I[2];
          cfg_r.swap_lines <= WB_DAT_I[3];
        end
        gci_frame_pkg::ADR_CFG_SLOT: cfg_r.group <= WB_DAT_I[4:0];
        gci_frame_pkg::ADR_PCM_MODE: {rate_r, pcm_master_r} <= WB_DAT_I[2:0];
        gci_frame_pkg::ADR_SLOT_SEL: {sel_num_r, sel_dir_r} <= WB_DAT_I[7:0];
        gci_frame_pkg::ADR_MON_TX:   mon_tx_r <= WB_DAT_I[7:0];
        gci_frame_pkg::ADR_CI_TX:    {mx_tx_r, mr_tx_r, ci_tx_r} <= WB_DAT_I[5:0];
        default: ;
      endcase
    end
  end

  // Slot table writes wait for the frame edge
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      pend_r     <= 1'b0;
      pend_idx_r <= '0;
      pend_ent_r <= gci_frame_pkg::SLOT_RESET;
    end else if (wr_ev && WB_ADR_I == gci_frame_pkg::ADR_SLOT_CFG) begin
      pend_r     <= 1'b1;
      pend_idx_r <= {sel_num_r, sel_dir_r};
      pend_ent_r <= gci_frame_pkg::slot_entry_type'(WB_DAT_I[6:0]);
    end else if (frame_go) begin
      pend_r     <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 256; i++) begin
        slot_tab[i] <= gci_frame_pkg::SLOT_RESET;
      end
    end else if (frame_go && pend_r) begin
      slot_tab[pend_idx_r] <= pend_ent_r;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      act_r  <= gci_frame_pkg::CFG_RESET;
      seen_r <= 1'b0;
    end else if (frame_go) begin
      act_r  <= cfg_r;
      seen_r <= 1'b1;
    end
  end

  // Pin synchroniser: {bit clock, sync, line a, line b}
  // Sync taken at the falling edge: the far master moves it on the rising one
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      meta_r    <= '0;
      sync_r    <= '0;
      c4_d_r    <= 1'b0;
      fs_fall_r <= 1'b0;
    end else begin
      meta_r <= {DOUBLE_RATE_BIT_CLOCK_I, FRAME_SYNC_8KHZ_I,
                 SERIAL_DATA_LINE_A_I, SERIAL_DATA_LINE_B_I};
      sync_r <= meta_r;
      c4_d_r <= sync_r[3];
      if (c4_d_r && !sync_r[3]) begin
        fs_fall_r <= sync_r[2];
      end
    end
  end

  // Clock generation as PCM master
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      div_r <= '0;
      c4_r  <= 1'b0;
    end else if (pcm_master_r) begin
      div_r <= (div_r == gci_frame_pkg::C4_DIV_LAST) ? '0 : div_r + 4'h1;
      if (div_r == gci_frame_pkg::C4_DIV_LAST) begin
        c4_r <= !c4_r;
      end
    end else begin
      div_r <= '0;
      c4_r  <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      c4_oe_n_r <= 1'b1;
      fs_oe_n_r <= 1'b1;
    end else begin
      c4_oe_n_r <= !pcm_master_r;
      fs_oe_n_r <= !pcm_master_r;
    end
  end

  // Slave mode follows the pins; no edge is assumed while they stand still
  assign edge_now = pcm_master_r ? (div_r == gci_frame_pkg::C4_DIV_LAST && !c4_r)
                                 : (sync_r[3] && !c4_d_r);
  assign fs_now   = pcm_master_r ? fs_r : fs_fall_r;
  assign frame_go = edge_now && fs_now;
  assign last_cnt = frame_last(rate_r);
  assign cnt_nxt  = fs_now ? '0 : cnt_r + 11'h1;
  assign slot_nx  = cnt_nxt[10:4];
  assign bit_nx   = cnt_nxt[3:1];
  assign half_nx  = cnt_nxt[0];
  assign slot_nn  = (slot_nx == last_cnt[10:4]) ? '0 : slot_nx + 7'h1;
  assign ld_ev    = edge_now && !half_nx && bit_nx == '0;
  assign smp_ev   = edge_now && half_nx;

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      cnt_r <= '0;
      fs_r  <= 1'b0;
    end else if (edge_now) begin
      cnt_r <= cnt_nxt;
      fs_r  <= pcm_master_r && (cnt_nxt == last_cnt);
    end
  end

  // Slot decode for the slot about to start
  always_comb begin
    tx_ent   = slot_tab[{slot_nx, 1'b0}];
    rx_ent   = slot_tab[{slot_nx, 1'b1}];
    in_grp   = (slot_nx[6:2] == act_r.group);
    pos      = slot_nx[1:0];
    auto_any = act_r.en && in_grp && (pos == gci_frame_pkg::POS_MON ||
                                      pos == gci_frame_pkg::POS_CI);
    ld_a     = !tx_ent.ch_dir && tx_ent.route == gci_frame_pkg::ROUTE_A_OUT;
    ld_b     = !tx_ent.ch_dir && tx_ent.route == gci_frame_pkg::ROUTE_B_OUT;
    sm_b     = rx_ent.ch_dir && rx_ent.route == gci_frame_pkg::ROUTE_A_OUT;
    sm_a     = rx_ent.ch_dir && rx_ent.route == gci_frame_pkg::ROUTE_B_OUT;
    ld_byte  = CH_TX_BYTE_I;
    if (auto_any) begin
      ld_a = !act_r.swap_lines;
      ld_b = act_r.swap_lines;
      sm_a = act_r.swap_lines;
      sm_b = !act_r.swap_lines;
      if (pos == gci_frame_pkg::POS_MON) begin
        ld_byte = mon_tx_r;
      end else begin
        ld_byte = {(!tx_ent.ch_dir && tx_ent.route != '0) ? CH_TX_BYTE_I[7:6]
                                                         : gci_frame_pkg::D_IDLE,
                   ci_tx_r, hs_order(act_r.swap_tx_hs, mr_tx_r, mx_tx_r)};
      end
    end
  end

  // Transmit: a new bit at each even bit clock edge, MSB first
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      tx_byte_r <= gci_frame_pkg::MON_IDLE;
      a_out_r   <= 1'b1;
      b_out_r   <= 1'b1;
      a_oe_n_r  <= 1'b1;
      b_oe_n_r  <= 1'b1;
    end else if (ld_ev) begin
      tx_byte_r <= ld_byte;
      a_out_r   <= ld_byte[7];
      b_out_r   <= ld_byte[7];
      a_oe_n_r  <= !ld_a;
      b_oe_n_r  <= !ld_b;
    end else if (edge_now && !half_nx) begin
      a_out_r   <= tx_byte_r[gci_frame_pkg::BIT_LAST - bit_nx];
      b_out_r   <= tx_byte_r[gci_frame_pkg::BIT_LAST - bit_nx];
    end
  end

  // Next slot's transmit channel is named half a slot ahead
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      ch_tx_num_r <= '0;
    end else if (edge_now && !half_nx && bit_nx == gci_frame_pkg::BIT_PREFETCH) begin
      ch_tx_num_r <= slot_tab[{slot_nn, 1'b0}].ch_num;
    end
  end

  // Receive: sample at odd edges, mid bit
  assign rx_byte = {rx_sh_r, (smp_a_r && sync_r[1]) || (smp_b_r && sync_r[0])};

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      smp_a_r     <= 1'b0;
      smp_b_r     <= 1'b0;
      rx_auto_r   <= 1'b0;
      rx_pos_r    <= '0;
      rx_ch_en_r  <= 1'b0;
      rx_ch_num_r <= '0;
      rx_sh_r     <= '0;
    end else if (ld_ev) begin
      smp_a_r     <= sm_a;
      smp_b_r     <= sm_b;
      rx_auto_r   <= auto_any;
      rx_pos_r    <= pos;
      rx_ch_en_r  <= rx_ent.ch_dir && rx_ent.route != '0;
      rx_ch_num_r <= rx_ent.ch_num;
    end else if (smp_ev) begin
      rx_sh_r     <= rx_byte[6:0];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      mon_rx_r <= gci_frame_pkg::MON_IDLE;
      ci_rx_r  <= '0;
      mr_rx_r  <= 1'b1;
      mx_rx_r  <= 1'b1;
    end else if (smp_ev && bit_nx == gci_frame_pkg::BIT_LAST && rx_auto_r) begin
      if (rx_pos_r == gci_frame_pkg::POS_MON) begin
        mon_rx_r <= rx_byte;
      end else begin
        ci_rx_r  <= rx_byte[5:2];
        {mr_rx_r, mx_rx_r} <= hs_order(act_r.swap_rx_hs, rx_byte[1], rx_byte[0]);
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      ch_rx_stb_r  <= 1'b0;
      ch_rx_num_r  <= '0;
      ch_rx_byte_r <= '0;
    end else begin
      ch_rx_stb_r <= smp_ev && bit_nx == gci_frame_pkg::BIT_LAST && rx_ch_en_r;
      if (smp_ev && bit_nx == gci_frame_pkg::BIT_LAST && rx_ch_en_r) begin
        ch_rx_num_r  <= rx_ch_num_r;
        ch_rx_byte_r <= rx_byte;
      end
    end
  end

  assign WB_ACK_O                     = ack_r;
  assign WB_DAT_O                     = dat_r;
  assign DOUBLE_RATE_BIT_CLOCK_O      = c4_r;
  assign DOUBLE_RATE_BIT_CLOCK_OE_N_O = c4_oe_n_r;
  assign FRAME_SYNC_8KHZ_O            = fs_r;
  assign FRAME_SYNC_8KHZ_OE_N_O       = fs_oe_n_r;
  assign SERIAL_DATA_LINE_A_O         = a_out_r;
  assign SERIAL_DATA_LINE_A_OE_N_O    = a_oe_n_r;
  assign SERIAL_DATA_LINE_B_O         = b_out_r;
  assign SERIAL_DATA_LINE_B_OE_N_O    = b_oe_n_r;
  assign CH_TX_NUM_O                  = ch_tx_num_r;
  assign CH_RX_NUM_O                  = ch_rx_num_r;
  assign CH_RX_BYTE_O                 = ch_rx_byte_r;
  assign CH_RX_STB_O                  = ch_rx_stb_r;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  AST_MASTER_CLOCK: assert property (
    pcm_master_r && $rose(c4_r) && $past(pcm_master_r) && !wr_ev
      |-> (c4_r[*6] ##1 !c4_r) or ##[1:7] !pcm_master_r)
    else $error("bit clock half period wrong in master mode");
  AST_SLAVE_PINS: assert property (
    !pcm_master_r ##1 !pcm_master_r |-> c4_oe_n_r && fs_oe_n_r && !c4_r)
    else $error("clock pins driven in slave mode");
  AST_MASTER_PINS: assert property (
    $rose(pcm_master_r) |-> ##1 (!c4_oe_n_r && !fs_oe_n_r))
    else $error("clock pins not driven in master mode");
  AST_MON_SLOT: assert property (
    ld_ev && auto_any && pos == gci_frame_pkg::POS_MON && !act_r.swap_lines
      |=> !a_oe_n_r && a_out_r == $past(mon_tx_r[7]))
    else $error("monitor byte not sent on line a");
  AST_MASTER_LINES: assert property (
    ld_ev && auto_any && !act_r.swap_lines |=> b_oe_n_r && !a_oe_n_r)
    else $error("GCI master drives wrong line");
  AST_LINE_SWAP: assert property (
    ld_ev && auto_any && act_r.swap_lines |=> !b_oe_n_r && a_oe_n_r)
    else $error("swapped lines not honoured");
  AST_TX_HS: assert property (
    ld_ev && auto_any && pos == gci_frame_pkg::POS_CI
      |=> tx_byte_r[1:0] == ($past(act_r.swap_tx_hs) ? {$past(mx_tx_r), $past(mr_tx_r)}
                                                    : {$past(mr_tx_r), $past(mx_tx_r)}))
    else $error("handshake bit order wrong");
  AST_ROUTE_A: assert property (
    ld_ev && !auto_any && !tx_ent.ch_dir && tx_ent.route == gci_frame_pkg::ROUTE_A_OUT
      |=> !a_oe_n_r ##1 !a_oe_n_r)
    else $error("routed slot not driven on line a");
  AST_FRAME_CFG: assert property (
    !frame_go |=> act_r == $past(act_r))
    else $error("active settings changed inside a frame");
  AST_RESET_OFF: assert property (
    $rose(NRST_I) |-> !act_r.en && !cfg_r.en)
    else $error("GCI enabled after reset");
endmodule

/* File: verification/gci_far_end.sv */
// Far-end GCI device: optional PCM clock master, sends a byte per slot, captures slot bytes.
// Assumes the bench resolves the shared pins and chooses its data lines.
`timescale 1ns/10ps
module gci_far_end (
  input  wire logic             gen_i,
  input  wire logic             bclk_i,
  input  wire logic             sync_i,
  input  wire logic             rx_i,
  input  wire logic [31:0][7:0] pat_i,
  output logic                  bclk_o,
  output logic                  sync_o,
  output logic                  tx_o
);
  logic [7:0] got [32];
  logic [9:0] cnt    = 10'h0;
  logic [9:0] c;
  logic [6:0] sh;
  logic       sy     = 1'b0;
  logic       rb     = 1'b0;
  logic       clk_r  = 1'b0;
  logic       sync_r = 1'b0;
  initial tx_o = 1'b1;
  // PCM clock runs free while this side is the PCM master
  always #32 clk_r = gen_i & ~clk_r;
  assign bclk_o = clk_r;
  assign sync_o = sync_r & gen_i;
  // Mid-period sampling, so pins that move on the rising edge never race
  always @(negedge bclk_i) begin
    sy <= sync_i;
    rb <= rx_i;
  end
  always @(posedge bclk_i) begin
    c = sy ? 10'h0 : cnt + 10'h1;
    cnt <= c;
    sync_r <= (c == 10'h1ff);
    if (!c[0]) tx_o <= pat_i[c[8:4]][3'h7 - c[3:1]];
    if (c[0]) sh <= {sh[5:0], rb};
    if (c[3:0] == 4'hf) got[c[8:4]] <= {sh, rb};
  end
endmodule

/* File: verification/tb_top.sv */
// Bench for the GCI frame embedder: Wishbone host, far-end device, frame checks.
// Assumes the design package; the far end makes a 64 ns bit clock as PCM master.
`timescale 1ns/10ps
module tb_top;
  localparam int LIMIT = 95000;
  logic             clk    = 1'b0;
  logic             nrst   = 1'b0;
  logic             cyc    = 1'b0;
  logic             stb    = 1'b0;
  logic             we     = 1'b0;
  logic [7:0]       adr    = 8'h0;
  logic [31:0]      dat    = 32'h0;
  logic [31:0]      rdat;
  logic [31:0]      q;
  logic             ack;
  logic             c_o, c_oe, s_o, s_oe, a_o, a_oe, b_o, b_oe;
  logic [3:0]       txn;
  logic [3:0]       rxn;
  logic [7:0]       txb    = 8'h0;
  logic [7:0]       rxb;
  logic             rxs;
  logic             p_gen  = 1'b0;
  logic             p_on_a = 1'b0;
  logic             alt    = 1'b0;
  logic             pc, ps, pt;
  logic [31:0][7:0] pat;
  logic [15:0][7:0] tab;
  logic [11:0]      rxq [$];
  int               failures = 0;
  int               checks   = 0;
  int               cycles   = 0;
  // Released lines show a changing level, not the last driven one
  wire clk_w  = !c_oe ? c_o : pc;
  wire sync_w = !s_oe ? s_o : ps;
  wire la     = !a_oe ? a_o : (p_on_a ? pt : alt);
  wire lb     = !b_oe ? b_o : (p_on_a ? alt : pt);

  gci_frame_embed i_dut (
    .CLK_SYS_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .DOUBLE_RATE_BIT_CLOCK_I(clk_w), .DOUBLE_RATE_BIT_CLOCK_O(c_o),
    .DOUBLE_RATE_BIT_CLOCK_OE_N_O(c_oe), .FRAME_SYNC_8KHZ_I(sync_w),
    .FRAME_SYNC_8KHZ_O(s_o), .FRAME_SYNC_8KHZ_OE_N_O(s_oe),
    .SERIAL_DATA_LINE_A_I(la), .SERIAL_DATA_LINE_A_O(a_o), .SERIAL_DATA_LINE_A_OE_N_O(a_oe),
    .SERIAL_DATA_LINE_B_I(lb), .SERIAL_DATA_LINE_B_O(b_o), .SERIAL_DATA_LINE_B_OE_N_O(b_oe),
    .CH_TX_NUM_O(txn), .CH_TX_BYTE_I(txb), .CH_RX_NUM_O(rxn), .CH_RX_BYTE_O(rxb),
    .CH_RX_STB_O(rxs)
  );
  gci_far_end i_far (
    .gen_i(p_gen), .bclk_i(clk_w), .sync_i(sync_w), .rx_i(p_on_a ? lb : la),
    .pat_i(pat), .bclk_o(pc), .sync_o(ps), .tx_o(pt)
  );

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    alt <= ~alt;
    txb <= tab[txn];
    if (rxs === 1'b1) rxq.push_back({rxn, rxb});
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_line(input logic [11:0] g, input logic [11:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rxq.delete();
  endtask
  // ms=1: PCM and GCI master on slot 4x; ms=0: slave, all swaps, slot 4x+1
  task automatic scen(input logic ms);
    logic [4:0] x;
    logic [6:0] s;
    logic [1:0] rt;
    logic [3:0] y, z;
    logic [7:0] mon, p;
    logic [5:0] ci;
    int         h, n;
    x   = 5'($urandom_range(7));
    s   = {x, 2'b00} + 7'(!ms);
    rt  = ms ? 2'h2 : 2'h3;
    y   = 4'($urandom_range(15, 1));
    z   = 4'($urandom_range(15, 1));
    mon = 8'($urandom);
    ci  = 6'($urandom);
    h   = 0;
    n   = 0;
    wb(1'b1, gci_frame_pkg::ADR_PCM_MODE, {31'h0, ms}, q);
    @(posedge clk);
    chk_reg({c_oe, s_oe}, ms ? 32'h0 : 32'h3);
    wb(1'b1, gci_frame_pkg::ADR_CFG_SLOT, {27'h0, x}, q);
    wb(1'b1, gci_frame_pkg::ADR_SLOT_SEL, {24'h0, s, 1'b0}, q);
    wb(1'b1, gci_frame_pkg::ADR_SLOT_CFG, {25'h0, rt, 1'b0, y}, q);
    wb(1'b1, gci_frame_pkg::ADR_SLOT_SEL, {24'h0, s, 1'b1}, q);
    wb(1'b1, gci_frame_pkg::ADR_SLOT_CFG, {25'h0, rt, 1'b1, z}, q);
    wb(1'b1, gci_frame_pkg::ADR_MON_TX, {24'h0, mon}, q);
    wb(1'b1, gci_frame_pkg::ADR_CI_TX, {26'h0, ci}, q);
    wb(1'b1, gci_frame_pkg::ADR_CFG_MAIN, ms ? 32'h1 : 32'hf, q);
    if (ms) begin
      while (s_o !== 1'b1) @(posedge clk);
      while (s_o === 1'b1) begin
        @(posedge clk);
        h++;
      end
      while (s_o !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      chk_reg(32'(h), 32'(2 * gci_frame_pkg::C4_HALF_CYC));
      chk_reg(32'(h + n), 32'(1024 * gci_frame_pkg::C4_HALF_CYC));
    end
    repeat (3) @(posedge sync_w);
    @(posedge clk);
    chk_line({4'h0, i_far.got[s]}, {4'h0, tab[y]});
    chk_line({4'h0, i_far.got[{x, 2'b10}]}, {4'h0, mon});
    chk_line({4'h0, i_far.got[{x, 2'b11}]},
             {6'h3, ci[3:0], ms ? ci[4] : ci[5], ms ? ci[5] : ci[4]});
    chk_line(rxq[$], {z, pat[s]});
    p = pat[{x, 2'b11}];
    wb(1'b0, gci_frame_pkg::ADR_CI_RX, 32'h0, q);
    chk_reg(q, ms ? {26'h0, p[0], p[1], p[5:2]} : {26'h0, p[1], p[0], p[5:2]});
    wb(1'b0, gci_frame_pkg::ADR_MON_RX, 32'h0, q);
    chk_reg(q, {24'h0, pat[{x, 2'b10}]});
  endtask

  initial begin
    void'($urandom(50));
    for (int k = 0; k < 32; k++) pat[k] = 8'($urandom);
    for (int k = 0; k < 16; k++) tab[k] = 8'($urandom);
    do_reset();
    // Whole map plus one unmapped word just past it
    for (int k = 0; k < 11; k++) begin
      wb(1'b0, 8'(k * 4), 32'h0, q);
      chk_reg(q, (k == 5 || k == 7) ? 32'hff : (k == 6 || k == 8) ? 32'h30 : 32'h0);
    end
    chk_reg({c_oe, s_oe, a_oe, b_oe}, 32'hf);
    wb(1'b1, gci_frame_pkg::ADR_PCM_MODE, {29'h0, gci_frame_pkg::RATE_128, 1'b0}, q);
    wb(1'b0, gci_frame_pkg::ADR_PCM_MODE, 32'h0, q);
    chk_reg(q, 32'h4);
    scen(1'b1);
    do_reset();
    p_gen  <= 1'b1;
    p_on_a <= 1'b1;
    scen(1'b0);
    stop_test();
  end
endmodule
